/* core/lbm_monitor.sv */
// Leaky bucket activity monitor with APB register access and interrupt
//
// Summary of operation
// RULE1: Every 128 ms window in which the input was failed or erratic adds one to the accumulator.
// RULE2: With no failure, the accumulator loses one per decay period of 1, 2, 4 or 8 windows.
// RULE3: A set alarm clears once the accumulator drains to the clear level, default 4.
// RULE4: The accumulator never exceeds the capacity, 1 to 255, default 8.
// RULE5: The alarm is raised when the accumulator reaches the raise level, default 6.
// RULE6: The accumulator holds at zero while the input stays good.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module lbm_monitor #(
  parameter longint WINDOW_CYCLES = lbm_pkg::WINDOW_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ref_fault,
  output logic             inactivity_alarm,
  output logic      [7:0]  bucket_level,
  output logic             irq
);
  typedef enum logic [1:0] {
    LBM_IDLE   = 2'b00,
    LBM_ACCESS = 2'b01
  } lbm_bus_e;

  typedef struct packed {
    lbm_bus_e                  bus;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    lbm_pkg::lbm_cfg_s         cfg;
    logic [7:0]                acc;
    logic                      alarm;
    logic                      fault_seen;
    logic [2:0]                decay_cnt;
    logic [lbm_pkg::IRQ_W-1:0] irq_stat;
    logic [lbm_pkg::IRQ_W-1:0] irq_en;
    logic                      irq;
  } lbm_state_s;

  lbm_state_s s_q;
  lbm_state_s s_d;
  logic       tick;

  lbm_window_timer #(
    .PERIOD (WINDOW_CYCLES)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  always_comb begin
    logic                      wr;
    logic                      rd;
    logic [7:0]                acc_n;
    logic [2:0]                decay_lim;
    lbm_pkg::lbm_evt_s         evt;
    logic [lbm_pkg::IRQ_W-1:0] clr;
    logic [lbm_pkg::IRQ_W-1:0] setv;
    wr        = 1'b0;
    rd        = 1'b0;
    acc_n     = 8'h00;
    decay_lim = 3'h0;
    evt       = '0;
    clr       = '0;
    setv      = '0;
    s_d       = s_q;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;

    // APB slave: one wait state, answer in access phase
    case (s_q.bus)
      LBM_IDLE: begin
        if (psel && !penable) begin
          s_d.bus = LBM_ACCESS;
        end
      end
      LBM_ACCESS: begin
        if (psel && penable && !s_q.pready) begin
          s_d.pready = 1'b1;
          wr         = pwrite;
          rd         = !pwrite;
        end else if (s_q.pready) begin
          s_d.bus = LBM_IDLE;
        end
      end
      default: begin
        s_d.bus = LBM_IDLE;
      end
    endcase

    if (wr || rd) begin
      s_d.prdata = 32'h0;
      if (paddr == lbm_pkg::ADDR_RAISE_LEVEL) begin
        s_d.prdata = {24'h0, s_q.cfg.raise_level};
        if (wr) s_d.cfg.raise_level = pwdata[7:0];
      end else if (paddr == lbm_pkg::ADDR_CLEAR_LEVEL) begin
        s_d.prdata = {24'h0, s_q.cfg.clear_level};
        if (wr) s_d.cfg.clear_level = pwdata[7:0];
      end else if (paddr == lbm_pkg::ADDR_CAPACITY) begin
        s_d.prdata = {24'h0, s_q.cfg.capacity};
        // Capacity of zero is not allowed; write ignored
        if (wr && pwdata[7:0] != 8'h00) s_d.cfg.capacity = pwdata[7:0];
      end else if (paddr == lbm_pkg::ADDR_DECAY_RATE) begin
        s_d.prdata = {30'h0, s_q.cfg.decay_rate};
        if (wr) s_d.cfg.decay_rate = pwdata[1:0];
      end else if (paddr == lbm_pkg::ADDR_STATUS) begin
        s_d.prdata = {15'h0, s_q.fault_seen, 7'h0, s_q.alarm, s_q.acc};
        s_d.pslverr = wr;
      end else if (paddr == lbm_pkg::ADDR_IRQ_STATUS) begin
        s_d.prdata = {29'h0, s_q.irq_stat};
        s_d.pslverr = wr;
      end else if (paddr == lbm_pkg::ADDR_IRQ_ENABLE) begin
        s_d.prdata = {29'h0, s_q.irq_en};
        if (wr) s_d.irq_en = pwdata[lbm_pkg::IRQ_W-1:0];
      end else if (paddr == lbm_pkg::ADDR_IRQ_CLEAR) begin
        if (wr) clr = pwdata[lbm_pkg::IRQ_W-1:0];
      end else begin
        s_d.pslverr = 1'b1;
      end
    end

    // Fault seen at any time during the current window
    if (ref_fault) s_d.fault_seen = 1'b1;

    // Decay period in windows
    case (s_q.cfg.decay_rate)
      2'h0:    decay_lim = 3'h0;
      2'h1:    decay_lim = 3'h1;
      2'h2:    decay_lim = 3'h3;
      default: decay_lim = 3'h7;
    endcase

    acc_n = s_q.acc;
    if (tick) begin
      evt.window_end = 1'b1;
      s_d.fault_seen = ref_fault;
      if (s_q.fault_seen || ref_fault) begin
        s_d.decay_cnt = 3'h0;
        if (s_q.acc < s_q.cfg.capacity) begin // RULE1
          acc_n = s_q.acc + 8'h01;
        end else begin
          acc_n = s_q.cfg.capacity; // RULE4
        end
      end else if (s_q.decay_cnt >= decay_lim) begin
        s_d.decay_cnt = 3'h0;
        if (s_q.acc != 8'h00) begin // RULE6
          acc_n = s_q.acc - 8'h01; // RULE2
        end
      end else begin
        s_d.decay_cnt = s_q.decay_cnt + 3'h1; // RULE2
      end
    end
    // Capacity lowered below the level clamps at once
    if (acc_n > s_q.cfg.capacity) begin
      acc_n = s_q.cfg.capacity; // RULE4
    end
    s_d.acc = acc_n;

    if (!s_q.alarm && acc_n >= s_q.cfg.raise_level && tick) begin
      s_d.alarm     = 1'b1; // RULE5
      evt.alarm_set = 1'b1;
    end else if (s_q.alarm && acc_n <= s_q.cfg.clear_level && tick) begin
      s_d.alarm     = 1'b0; // RULE3
      evt.alarm_clr = 1'b1;
    end

    setv[lbm_pkg::IRQ_RAISED]  = evt.alarm_set;
    setv[lbm_pkg::IRQ_CLEARED] = evt.alarm_clr;
    setv[lbm_pkg::IRQ_WINDOW]  = evt.window_end;
    // Set wins over clear
    s_d.irq_stat = (s_q.irq_stat & ~clr) | setv;
    s_d.irq      = |(s_d.irq_stat & s_d.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q                 <= '0;
      s_q.bus             <= LBM_IDLE;
      s_q.cfg.raise_level <= lbm_pkg::RST_RAISE_LEVEL;
      s_q.cfg.clear_level <= lbm_pkg::RST_CLEAR_LEVEL;
      s_q.cfg.capacity    <= lbm_pkg::RST_CAPACITY;
      s_q.cfg.decay_rate  <= lbm_pkg::RST_DECAY_RATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata           = s_q.prdata;
  assign pready           = s_q.pready;
  assign pslverr          = s_q.pslverr;
  assign inactivity_alarm = s_q.alarm;
  assign bucket_level     = s_q.acc;
  assign irq              = s_q.irq;
endmodule

/* core/lbm_pkg.sv */
// Package: register map, reset values and timing for the leaky bucket monitor
package lbm_pkg;
  // Printed offsets are indices; byte address is four times the index
  localparam logic [7:0]  IDX_RAISE_LEVEL   = 8'h50;
  localparam logic [7:0]  IDX_CLEAR_LEVEL   = 8'h51;
  localparam logic [7:0]  IDX_CAPACITY      = 8'h52;
  localparam logic [7:0]  IDX_DECAY_RATE    = 8'h53;
  localparam logic [11:0] ADDR_RAISE_LEVEL  = {2'h0, IDX_RAISE_LEVEL, 2'h0};
  localparam logic [11:0] ADDR_CLEAR_LEVEL  = {2'h0, IDX_CLEAR_LEVEL, 2'h0};
  localparam logic [11:0] ADDR_CAPACITY     = {2'h0, IDX_CAPACITY, 2'h0};
  localparam logic [11:0] ADDR_DECAY_RATE   = {2'h0, IDX_DECAY_RATE, 2'h0};
  localparam logic [11:0] ADDR_STATUS       = 12'h200;
  localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h204;
  localparam logic [11:0] ADDR_IRQ_ENABLE   = 12'h208;
  localparam logic [11:0] ADDR_IRQ_CLEAR    = 12'h20C;

  localparam logic [7:0]  RST_RAISE_LEVEL   = 8'h06;
  localparam logic [7:0]  RST_CLEAR_LEVEL   = 8'h04;
  localparam logic [7:0]  RST_CAPACITY      = 8'h08;
  localparam logic [1:0]  RST_DECAY_RATE    = 2'h0;

  // Window timing
  localparam longint WINDOW_MS      = 128;
  localparam longint CLK_HZ         = 25000000;
  localparam longint WINDOW_CYCLES  = (WINDOW_MS * CLK_HZ) / 1000;

  // Interrupt bit positions
  localparam int IRQ_RAISED  = 0;
  localparam int IRQ_CLEARED = 1;
  localparam int IRQ_WINDOW  = 2;
  localparam int IRQ_W       = 3;

  typedef struct packed {
    logic [7:0] raise_level;
    logic [7:0] clear_level;
    logic [7:0] capacity;
    logic [1:0] decay_rate;
  } lbm_cfg_s;

  typedef struct packed {
    logic       window_end;
    logic       alarm_set;
    logic       alarm_clr;
  } lbm_evt_s;
endpackage

/* core/lbm_window_timer.sv */
// Window timer: one-cycle pulse at the end of each monitoring window
`timescale 1ns/1ns
module lbm_window_timer #(
  parameter longint PERIOD = lbm_pkg::WINDOW_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } lbm_tmr_s;

  lbm_tmr_s s_q;
  lbm_tmr_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 32'(PERIOD - 1)) begin
      s_d.cnt  = 32'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

/* tb/lbm_monitor_properties.sv */
// Checker: port properties of the leaky bucket monitor
`timescale 1ns/1ns
module lbm_monitor_properties #(
  parameter longint WINDOW_CYCLES = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ref_fault,
  input wire logic        inactivity_alarm,
  input wire logic [7:0]  bucket_level,
  input wire logic        irq
);
  logic [7:0] cap_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Capacity as last written, zero ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cap_q <= lbm_pkg::RST_CAPACITY;
    else if (pready && psel && pwrite && paddr == lbm_pkg::ADDR_CAPACITY && pwdata[7:0] != 8'h00) cap_q <= pwdata[7:0];
  end
  AST_RISE_BY_ONE: assert property (
    bucket_level > $past(bucket_level) |-> bucket_level == $past(bucket_level) + 8'h01) else $error("rise not one");
  AST_FALL_BY_ONE: assert property (
    bucket_level < $past(bucket_level) |-> bucket_level == $past(bucket_level) - 8'h01) else $error("fall not one");
  AST_CLEAR_ON_DRAIN: assert property (
    $fell(inactivity_alarm) |-> bucket_level < $past(bucket_level)) else $error("alarm cleared without drain");
  AST_CAP_LIMIT: assert property (
    bucket_level <= cap_q) else $error("bucket above capacity");
  AST_RAISE_ON_FILL: assert property (
    $rose(inactivity_alarm) |-> bucket_level > $past(bucket_level)) else $error("alarm raised without fill");
  AST_ZERO_FLOOR: assert property (
    $past(bucket_level) == 8'h00 |-> bucket_level <= 8'h01) else $error("bucket wrapped below zero");
  AST_READY_LATENCY: assert property (
    psel && penable && !$past(penable) |=> pready) else $error("pready late");
  AST_READY_PULSE: assert property (
    pready |=> !pready) else $error("pready too long");
  C_RAISE: cover property ($rose(inactivity_alarm));
  C_CLEAR: cover property ($fell(inactivity_alarm));
  C_FULL: cover property (bucket_level == cap_q);
endmodule
bind lbm_monitor lbm_monitor_properties #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_fault(ref_fault),
  .inactivity_alarm(inactivity_alarm), .bucket_level(bucket_level), .irq(irq));

/* tb/lbm_ref_source.sv */
// Partner model: reference source that turns erratic on command
`timescale 1ns/1ns
module lbm_ref_source (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fail_en,
  output logic      ref_fault
);
  logic [2:0] ph_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph_q <= 3'h0;
    else ph_q <= ph_q + 3'h1;
  end
  // One bad cycle in eight while erratic
  assign ref_fault = fail_en && (ph_q == 3'h5);
endmodule

/* tb/testbench.sv */
// Testbench: random fault windows, registers and interrupt
`timescale 1ns/1ns
module testbench;
  localparam int WC = 20;
  localparam int CAP = 7;
  localparam int CLR = 3;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fail_en = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic        pready, pslverr, ref_fault, alarm, irq, er;
  logic [7:0]  lvl;
  int          cyc = 0, acc = 0, dcnt = 0, rate = 0, j, miscompares = 0, n_compared = 0, seed = 32'h3A1159A4;
  bit          alm = 0, stk = 0, f;
  always #20 pclk = ~pclk;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) cyc <= 0;
    else cyc <= cyc + 1;
  end
  always @(posedge pclk) begin
    if (cyc > 4000) begin
      miscompares++;
      complete_run;
    end
  end
  lbm_monitor #(.WINDOW_CYCLES(WC)) u_lbm_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_fault(ref_fault), .inactivity_alarm(alarm), .bucket_level(lvl), .irq(irq));
  lbm_ref_source u_lbm_ref_source (.pclk(pclk), .presetn(presetn), .fail_en(fail_en), .ref_fault(ref_fault));
  task automatic complete_run;
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_to(input int n);
    while (cyc < n) @(posedge pclk);
  endtask
  // Expected bucket, alarm and sticky raise flag after one window
  function automatic void step(input bit fl);
    if (fl) begin
      acc = (acc >= CAP) ? CAP : acc + 1;
      dcnt = 0;
    end else if (dcnt == (1 << rate) - 1) begin
      dcnt = 0;
      acc = (acc > 0) ? acc - 1 : 0;
    end else dcnt++;
    if (acc >= int'(lbm_pkg::RST_RAISE_LEVEL)) begin
      stk = stk | !alm;
      alm = 1;
    end else if (acc <= CLR) alm = 0;
  endfunction
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, lbm_pkg::ADDR_CLEAR_LEVEL, 32'h0);
    chk("clear_level", 8'h04, rd[7:0]);
    apb(1'b1, lbm_pkg::ADDR_CLEAR_LEVEL, CLR);
    apb(1'b0, lbm_pkg::ADDR_CAPACITY, 32'h0);
    chk("capacity", 8'h08, rd[7:0]);
    apb(1'b1, lbm_pkg::ADDR_CAPACITY, CAP);
    apb(1'b0, 12'h300, 32'h0);
    chk("pslverr", 8'h01, 8'(er));
    for (int k = 1; k <= 160; k++) begin
      j = (k - 1) % 40;
      f = j != 1 && (j == 0 || j < 8 || ($random(seed) & 7) == 0);
      wait_to(WC * k);
      if (j == 1) begin
        rate = (k - 1) / 40;
        apb(1'b1, lbm_pkg::ADDR_DECAY_RATE, rate);
        apb(1'b1, lbm_pkg::ADDR_IRQ_CLEAR, 32'h7);
        apb(1'b1, lbm_pkg::ADDR_IRQ_ENABLE, rate & 1);
        stk = 0;
      end
      wait_to(WC * k + 2);
      fail_en <= f;
      wait_to(WC * k + 12);
      chk("bucket_level", 8'(acc), lvl);
      chk("alarm", 8'(alm), 8'(alarm));
      chk("irq", 8'(stk & rate[0]), 8'(irq));
      wait_to(WC * k + 16);
      fail_en <= 1'b0;
      step(f);
    end
    complete_run;
  end
endmodule
